// File: verilog/tmb_timer.sv
// Event-driven 16-bit timer/counter with APB register slave
//
// The APB interface to the registers was decided locally.
`timescale 1ns/10ps
`default_nettype none

// Function
// - With the interrupt enable bit set, raise interrupt request whenever the capture flag is set.
// - Flag clears on write of one, or on compare read in capture modes.
// - Periodic, time-out and single-shot modes flag when counter equals top value.
// - Frequency mode: on selected edge capture counter, restart from zero, set flag.
// - Capture-on-event mode: on event load counter into compare register, set flag.
// - Pulse width: one edge restarts count, opposite edge captures and sets flag.
// - Frequency plus width: flag on second selected edge, where the counter stops.
// - Eight-bit PWM: flag when counter reaches compare low byte, the top value.
// - Read-only run bit shows counter running; writes never set it.
// - Debug-run clear: timer halts in break debug and ignores events.
// - Debug-run set: timer keeps counting and taking events in break debug.
// - One shared byte latch, software readable and writable, serves the counter, and the compare register outside PWM mode.
// - Counter is a byte pair, low byte at base, high byte next; resets zero.
// - Software write to the counter beats internal counting in the same cycle.
// - In capture operation compare register holds counter value at capture moment.
// - In periodic, time-out and single-shot modes compare register is the top.
// - In PWM mode compare bytes are independent: low sets period, high is only stored and read back.
// - Compare register is a byte pair, low byte at base, high next; resets zero.
// - Three-bit mode field selects one of eight operating modes.
// - Capture events are acted on only while event input enable is set.
module tmb_timer (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire tmb_pkg::tmb_apb_req_t apb_req,
  output var  logic [31:0]          prdata,
  output var  logic                 pready,
  output var  logic                 pslverr,
  input  wire logic                 event_in,
  input  wire logic                 debug_break,
  output var  logic                 irq
);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  logic [5:0]  idx;
  logic [7:0]  wb;
  logic        setup_ph;
  logic        done;
  logic        wr;
  logic        rd;
  logic        rd_setup;
  logic [7:0]  rd_byte;
  logic        hit;

  logic                   enable_bit;
  tmb_pkg::tmb_mode_t     mode;
  logic                   edge_bit;
  logic                   event_input_enable;
  logic                   grab_irq_bit;
  logic                   irq_flag;
  logic                   run_bit;
  logic                   run_in_debug_bit;
  logic [7:0]             shared_byte_latch;
  logic [15:0]            counter_value;
  logic [15:0]            compare_top_value;
  logic                   counting;
  tmb_pkg::tmb_fp_state_t fp_state;
  logic                   ev_prev;

  logic                   eight_bit_pwm_mode;
  logic                   grab_irq_bit_mode;
  logic                   halted;
  logic                   tick;
  logic                   ev_ok;
  logic                   pos_e;
  logic                   neg_e;
  logic                   sel_e;
  logic                   opp_e;
  logic                   start_e;
  logic [15:0]            next_cnt;
  logic                   next_counting;
  tmb_pkg::tmb_fp_state_t next_fp;
  logic                   cap;
  logic                   set_flag;
  logic                   clr_flag;

  assign idx      = apb_req.paddr[tmb_pkg::APB_ADDR_W-1:2];
  assign wb       = apb_req.pwdata[7:0];
  assign setup_ph = apb_req.psel & apb_req.penable & ~pready;
  assign done     = apb_req.psel & apb_req.penable & pready;
  assign wr       = done & apb_req.pwrite;
  assign rd       = done & ~apb_req.pwrite;
  assign rd_setup = setup_ph & ~apb_req.pwrite;
  assign eight_bit_pwm_mode     = (mode == tmb_pkg::MODE_EIGHT_BIT_PWM_MODE);
  assign grab_irq_bit_mode = (mode == tmb_pkg::MODE_CAPTURE) | (mode == tmb_pkg::MODE_FREQUENCY) |
                     (mode == tmb_pkg::MODE_WIDTH) | (mode == tmb_pkg::MODE_FREQ_WID);

  always_comb begin
    hit     = 1'b1;
    rd_byte = tmb_pkg::RST_BYTE;
    unique case (idx)
      tmb_pkg::IDX_CTRL_A:     rd_byte[tmb_pkg::BIT_ENABLE] = enable_bit;
      tmb_pkg::IDX_CTRL_TWO:   rd_byte[2:0] = mode;
      tmb_pkg::IDX_EVENT_CTRL: begin
        rd_byte[tmb_pkg::BIT_EDGE]     = edge_bit;
        rd_byte[tmb_pkg::BIT_EVENT_EN] = event_input_enable;
      end
      tmb_pkg::IDX_IRQ_EN:     rd_byte[tmb_pkg::BIT_GRAB_IRQ] = grab_irq_bit;
      tmb_pkg::IDX_IRQ_FLAG:   rd_byte[tmb_pkg::BIT_GRAB_IRQ] = irq_flag;
      tmb_pkg::IDX_RUN_STAT:   rd_byte[tmb_pkg::BIT_RUN] = run_bit;
      tmb_pkg::IDX_DEBUG:      rd_byte[tmb_pkg::BIT_DEBUG_RUN] = run_in_debug_bit;
      tmb_pkg::IDX_LATCH:      rd_byte = shared_byte_latch;
      tmb_pkg::IDX_CNT_LO:     rd_byte = counter_value[7:0];
      tmb_pkg::IDX_CNT_HI:     rd_byte = shared_byte_latch;
      tmb_pkg::IDX_CMP_LO:     rd_byte = compare_top_value[7:0];
      tmb_pkg::IDX_CMP_HI:     rd_byte = eight_bit_pwm_mode ? compare_top_value[15:8]
                                              : shared_byte_latch;
      default:                 hit = 1'b0;
    endcase
  end

  // ****************************************************************
  // APB answer: one wait state, every access
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= tmb_pkg::RD_IDLE;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & ~hit;
      if (rd_setup) begin
        prdata <= {24'h00_0000, rd_byte};
      end else if (!setup_ph) begin
        prdata <= tmb_pkg::RD_IDLE;
      end
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_bit         <= 1'b0;
      mode               <= tmb_pkg::MODE_PERIODIC;
      edge_bit           <= 1'b0;
      event_input_enable <= 1'b0;
      grab_irq_bit       <= 1'b0;
      run_in_debug_bit   <= 1'b0;
    end else if (wr) begin
      if (idx == tmb_pkg::IDX_CTRL_A) begin
        enable_bit <= wb[tmb_pkg::BIT_ENABLE];
      end
      if (idx == tmb_pkg::IDX_CTRL_TWO) begin
        mode <= tmb_pkg::tmb_mode_t'(wb[2:0]);
      end
      if (idx == tmb_pkg::IDX_EVENT_CTRL) begin
        edge_bit           <= wb[tmb_pkg::BIT_EDGE];
        event_input_enable <= wb[tmb_pkg::BIT_EVENT_EN];
      end
      if (idx == tmb_pkg::IDX_IRQ_EN) begin
        grab_irq_bit <= wb[tmb_pkg::BIT_GRAB_IRQ];
      end
      if (idx == tmb_pkg::IDX_DEBUG) begin
        run_in_debug_bit <= wb[tmb_pkg::BIT_DEBUG_RUN];
      end
    end
  end

  // ****************************************************************
  // Shared byte latch
  // ****************************************************************
  // Latched with the read data so both bytes come from one snapshot
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shared_byte_latch <= tmb_pkg::RST_BYTE;
    end else if (wr && (idx == tmb_pkg::IDX_LATCH || idx == tmb_pkg::IDX_CNT_LO ||
                        (idx == tmb_pkg::IDX_CMP_LO && !eight_bit_pwm_mode))) begin
      shared_byte_latch <= wb;
    end else if (rd_setup && idx == tmb_pkg::IDX_CNT_LO) begin
      shared_byte_latch <= counter_value[15:8];
    end else if (rd_setup && idx == tmb_pkg::IDX_CMP_LO && !eight_bit_pwm_mode) begin
      shared_byte_latch <= compare_top_value[15:8];
    end
  end

  // ****************************************************************
  // Event edges and debug halt
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_prev <= 1'b0;
    end else begin
      ev_prev <= event_in;
    end
  end

  assign halted  = debug_break & ~run_in_debug_bit;
  assign tick    = enable_bit & ~halted;
  assign ev_ok   = event_input_enable & ~halted;
  assign pos_e   = event_in & ~ev_prev;
  assign neg_e   = ~event_in & ev_prev;
  assign sel_e   = ev_ok & (edge_bit ? neg_e : pos_e);
  assign opp_e   = ev_ok & (edge_bit ? pos_e : neg_e);
  assign start_e = ev_ok & (edge_bit ? (pos_e | neg_e) : pos_e);

  // ****************************************************************
  // Counting engine
  // ****************************************************************
  always_comb begin
    next_cnt      = counter_value;
    next_counting = counting;
    next_fp       = fp_state;
    cap           = 1'b0;
    set_flag      = 1'b0;
    if (tick) begin
      unique case (mode)
        tmb_pkg::MODE_PERIODIC: begin
          next_counting = 1'b1;
          if (counter_value == compare_top_value) begin
            set_flag = 1'b1;
            next_cnt = tmb_pkg::RST_WORD;
          end else begin
            next_cnt = counter_value + 16'h0001;
          end
        end
        tmb_pkg::MODE_TIMEOUT: begin
          if (sel_e) begin
            next_counting = 1'b1;
          end else if (opp_e) begin
            next_counting = 1'b0;
          end
          if (counting) begin
            if (counter_value == compare_top_value) begin
              set_flag = 1'b1;
              next_cnt = tmb_pkg::RST_WORD;
            end else begin
              next_cnt = counter_value + 16'h0001;
            end
          end
        end
        tmb_pkg::MODE_CAPTURE: begin
          next_counting = 1'b1;
          next_cnt      = counter_value + 16'h0001;
          if (sel_e) begin
            cap      = 1'b1;
            set_flag = 1'b1;
          end
        end
        tmb_pkg::MODE_FREQUENCY: begin
          next_counting = 1'b1;
          if (sel_e) begin
            cap      = 1'b1;
            set_flag = 1'b1;
            next_cnt = tmb_pkg::RST_WORD;
          end else begin
            next_cnt = counter_value + 16'h0001;
          end
        end
        tmb_pkg::MODE_WIDTH: begin
          next_counting = 1'b1;
          if (sel_e) begin
            next_cnt = tmb_pkg::RST_WORD;
          end else begin
            next_cnt = counter_value + 16'h0001;
            if (opp_e) begin
              cap      = 1'b1;
              set_flag = 1'b1;
            end
          end
        end
        tmb_pkg::MODE_FREQ_WID: begin
          unique case (fp_state)
            tmb_pkg::FP_IDLE: begin
              next_counting = 1'b0;
              if (sel_e) begin
                next_cnt      = tmb_pkg::RST_WORD;
                next_counting = 1'b1;
                next_fp       = tmb_pkg::FP_WIDTH;
              end
            end
            tmb_pkg::FP_WIDTH: begin
              next_cnt = counter_value + 16'h0001;
              if (opp_e) begin
                cap     = 1'b1;
                next_fp = tmb_pkg::FP_PERIOD;
              end
            end
            tmb_pkg::FP_PERIOD: begin
              if (sel_e) begin
                next_counting = 1'b0;
                set_flag      = 1'b1;
                next_fp       = tmb_pkg::FP_DONE;
              end else begin
                next_cnt = counter_value + 16'h0001;
              end
            end
            tmb_pkg::FP_DONE: begin
              // Rearm only once software has taken the result
              next_counting = 1'b0;
              if (!irq_flag) begin
                next_fp = tmb_pkg::FP_IDLE;
              end
            end
          endcase
        end
        tmb_pkg::MODE_SINGLE: begin
          if (!counting) begin
            if (start_e) begin
              next_counting = 1'b1;
              next_cnt      = tmb_pkg::RST_WORD;
            end
          end else if (counter_value == compare_top_value) begin
            set_flag      = 1'b1;
            next_counting = 1'b0;
          end else begin
            next_cnt = counter_value + 16'h0001;
          end
        end
        tmb_pkg::MODE_EIGHT_BIT_PWM_MODE: begin
          next_counting = 1'b1;
          if (counter_value[7:0] == compare_top_value[7:0]) begin
            set_flag = 1'b1;
            next_cnt = tmb_pkg::RST_WORD;
          end else begin
            next_cnt = {8'h00, counter_value[7:0] + 8'h01};
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counting <= 1'b0;
      fp_state <= tmb_pkg::FP_IDLE;
      run_bit  <= 1'b0;
    end else begin
      counting <= enable_bit & next_counting;
      fp_state <= (enable_bit && mode == tmb_pkg::MODE_FREQ_WID) ? next_fp : tmb_pkg::FP_IDLE;
      run_bit  <= tick & next_counting;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value <= tmb_pkg::RST_WORD;
    end else if (wr && idx == tmb_pkg::IDX_CNT_HI) begin
      counter_value <= {wb, shared_byte_latch};
    end else begin
      counter_value <= next_cnt;
    end
  end

  // ****************************************************************
  // Compare / capture register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_top_value <= tmb_pkg::RST_WORD;
    end else if (wr && idx == tmb_pkg::IDX_CMP_HI) begin
      if (eight_bit_pwm_mode) begin
        compare_top_value[15:8] <= wb;
      end else begin
        compare_top_value <= {wb, shared_byte_latch};
      end
    end else if (wr && idx == tmb_pkg::IDX_CMP_LO && eight_bit_pwm_mode) begin
      compare_top_value[7:0] <= wb;
    end else if (cap) begin
      compare_top_value <= counter_value;
    end
  end

  // ****************************************************************
  // Capture flag and interrupt request
  // ****************************************************************
  assign clr_flag = (wr && idx == tmb_pkg::IDX_IRQ_FLAG && wb[tmb_pkg::BIT_GRAB_IRQ]) ||
                    (rd && idx == tmb_pkg::IDX_CMP_LO && grab_irq_bit_mode);

  // A new event in the clearing cycle is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag <= 1'b0;
    end else begin
      irq_flag <= set_flag | (irq_flag & ~clr_flag);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= grab_irq_bit & irq_flag;
    end
  end

endmodule : tmb_timer

`default_nettype wire

// File: verilog/tmb_pkg.sv
// Shared constants, types and register map of the event timer
package tmb_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam int         APB_ADDR_W     = 8;
  localparam int         REG_IDX_W      = 6;
  localparam logic [5:0] IDX_CTRL_A     = 6'h00;
  localparam logic [5:0] IDX_CTRL_TWO   = 6'h01;
  localparam logic [5:0] IDX_EVENT_CTRL = 6'h04;
  localparam logic [5:0] IDX_IRQ_EN     = 6'h05;
  localparam logic [5:0] IDX_IRQ_FLAG   = 6'h06;
  localparam logic [5:0] IDX_RUN_STAT   = 6'h07;
  localparam logic [5:0] IDX_DEBUG      = 6'h08;
  localparam logic [5:0] IDX_LATCH      = 6'h09;
  localparam logic [5:0] IDX_CNT_LO     = 6'h0A;
  localparam logic [5:0] IDX_CNT_HI     = 6'h0B;
  localparam logic [5:0] IDX_CMP_LO     = 6'h0C;
  localparam logic [5:0] IDX_CMP_HI     = 6'h0D;

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int          BIT_ENABLE    = 0;
  localparam int          BIT_EVENT_EN  = 0;
  localparam int          BIT_EDGE      = 4;
  localparam int          BIT_GRAB_IRQ  = 0;
  localparam int          BIT_RUN       = 0;
  localparam int          BIT_DEBUG_RUN = 0;
  localparam int          MODE_LSB      = 0;
  localparam logic [7:0]  RST_BYTE      = 8'h00;
  localparam logic [15:0] RST_WORD      = 16'h0000;
  localparam logic [31:0] RD_IDLE       = 32'h0000_0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    MODE_PERIODIC  = 3'h0,
    MODE_TIMEOUT   = 3'h1,
    MODE_CAPTURE   = 3'h2,
    MODE_FREQUENCY = 3'h3,
    MODE_WIDTH     = 3'h4,
    MODE_FREQ_WID  = 3'h5,
    MODE_SINGLE    = 3'h6,
    MODE_EIGHT_BIT_PWM_MODE      = 3'h7
  } tmb_mode_t;

  typedef enum logic [1:0] {
    FP_IDLE,
    FP_WIDTH,
    FP_PERIOD,
    FP_DONE
  } tmb_fp_state_t;

  typedef struct packed {
    logic                  psel;
    logic                  penable;
    logic                  pwrite;
    logic [APB_ADDR_W-1:0] paddr;
    logic [31:0]           pwdata;
  } tmb_apb_req_t;

endpackage : tmb_pkg

// File: testbench/tmb_timer_assertions.sv
// Concurrent checks on the event timer pins, bound into the design
`timescale 1ns/10ps
`default_nettype none
module tmb_timer_chk (
  input wire logic                  pclk,
  input wire logic                  presetn,
  input wire tmb_pkg::tmb_apb_req_t apb_req,
  input wire logic [31:0]           prdata,
  input wire logic                  pready,
  input wire logic                  pslverr,
  input wire logic                  event_in,
  input wire logic                  debug_break,
  input wire logic                  irq
);
  logic       done;
  logic       mapped;
  logic       halt;
  logic       en_q;
  logic       dbg_q;
  logic [5:0] idx;
  assign done   = apb_req.psel && apb_req.penable && pready;
  assign idx    = apb_req.paddr[7:2];
  assign mapped = (idx <= 6'h01) || (idx >= 6'h04 && idx <= 6'h0D);
  assign halt   = debug_break && !dbg_q;
  // Shadows of control bits, so the pins alone can be judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      en_q <= 1'b0;
    else if (done && apb_req.pwrite && idx == tmb_pkg::IDX_IRQ_EN)
      en_q <= apb_req.pwdata[tmb_pkg::BIT_GRAB_IRQ];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      dbg_q <= 1'b0;
    else if (done && apb_req.pwrite && idx == tmb_pkg::IDX_DEBUG)
      dbg_q <= apb_req.pwdata[tmb_pkg::BIT_DEBUG_RUN];
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_wait;
    apb_req.psel && apb_req.penable && !pready;
  endsequence
  sequence s_halted_read;
    halt ##1 halt ##1 (done && !apb_req.pwrite && idx == tmb_pkg::IDX_RUN_STAT);
  endsequence
  chk_one_wait: assert property (s_wait |=> pready)
    else $error("ready not after one wait state");
  chk_ready_pulse: assert property (pready |-> apb_req.psel && apb_req.penable ##1 !pready)
    else $error("ready outside access or too long");
  chk_err_decode: assert property (pready |-> pslverr == !mapped)
    else $error("error response does not match decode");
  chk_rdata_idle: assert property (prdata[31:8] == 24'h0 && (pready && !apb_req.pwrite || prdata == 32'h0))
    else $error("read data outside a read or in reserved bits");
  chk_irq_needs_en: assert property (irq |-> $past(en_q))
    else $error("interrupt while not enabled");
  chk_irq_clear_cause: assert property ($fell(irq) |-> $past(done, 2))
    else $error("interrupt dropped without an access");
  chk_halt_no_irq: assert property ($rose(irq) && $past(en_q, 2) |-> !$past(halt, 2))
    else $error("flag set while halted");
  chk_halt_run_bit: assert property (s_halted_read |-> prdata == 32'h0)
    else $error("run bit set while halted");
endmodule : tmb_timer_chk

bind tmb_timer tmb_timer_chk u_chk (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .event_in(event_in), .debug_break(debug_break), .irq(irq)
);
`default_nettype wire

// File: testbench/tmb_cpu_model.sv
// Processor-side bus master model for the timer registers
`timescale 1ns/10ps
`default_nettype none
module tmb_cpu_model (
  input  wire logic                  pclk,
  input  wire logic                  pready,
  input  wire logic [31:0]           prdata,
  output var  tmb_pkg::tmb_apb_req_t apb_req
);
  logic [33:0] exp_q[$];
  logic [31:0] rdata;
  initial apb_req = '0;
  // One access; e is {skip, error, data} for the monitor
  task automatic xfer(input logic w, input logic [5:0] idx, input logic [7:0] d,
                      input logic [33:0] e);
    @(posedge pclk);
    apb_req.psel   <= 1'b1;
    apb_req.pwrite <= w;
    apb_req.paddr  <= {idx, 2'b00};
    apb_req.pwdata <= {24'h0, d};
    exp_q.push_back(e);
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    // Released lines must not keep looking valid
    apb_req.paddr   <= ~apb_req.paddr;
    apb_req.pwdata  <= ~apb_req.pwdata;
  endtask : xfer
endmodule : tmb_cpu_model
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the event timer
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic                  pclk = 1'b0;
  logic                  presetn;
  logic                  event_in;
  logic                  debug_break;
  tmb_pkg::tmb_apb_req_t apb_req;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  irq;
  int                    failures = 0;
  int                    cmp_count = 0;
  int                    cyc = 0;
  logic [31:0]           rnd = 32'h7B74;
  logic [33:0]           e;
  logic [15:0]           t_ev, t1, c1, c2;

  always #10 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;

  tmb_timer dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_in(event_in), .debug_break(debug_break),
    .irq(irq));
  tmb_cpu_model cpu (.pclk(pclk), .pready(pready), .prdata(prdata), .apb_req(apb_req));

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic check(input logic [32:0] seen, input logic [32:0] want);
    cmp_count++;
    if (seen !== want) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    cpu.xfer(1'b1, idx, d, {2'b00, 32'h0});
  endtask : wr
  task automatic rd(input logic [5:0] idx, input logic [7:0] d);
    cpu.xfer(1'b0, idx, 8'h00, {2'b00, 24'h0, d});
  endtask : rd
  task automatic rdx(input logic [5:0] idx);
    cpu.xfer(1'b0, idx, 8'h00, {1'b1, 33'h0});
  endtask : rdx
  task automatic pulse(input int hi);
    @(posedge pclk);
    event_in <= 1'b1;
    t_ev = cyc[15:0];
    repeat (hi) @(posedge pclk);
    event_in <= 1'b0;
  endtask : pulse
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    check({32'h0, irq}, 33'h1);
  endtask : wait_irq
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : summarize

  // ****************************************************************
  // Monitor and watchdog
  // ****************************************************************
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      e = cpu.exp_q.pop_front();
      if (!e[33]) check({pslverr, prdata}, e[32:0]);
    end
  end
  initial begin
    #400000;
    failures++;
    summarize();
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    presetn = 1'b0;
    event_in = 1'b0;
    debug_break = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 5; i <= 13; i++) rd(6'(i), 8'h00);
    cpu.xfer(1'b1, 6'h02, 8'hFF, {2'b01, 32'h0});
    cpu.xfer(1'b0, 6'h3F, 8'h00, {2'b01, 32'h0});
    wr(tmb_pkg::IDX_RUN_STAT, 8'hFF);
    rd(tmb_pkg::IDX_RUN_STAT, 8'h00);
    $display("test reset_and_decode done");
    rnd = lfsr_next(rnd);
    wr(tmb_pkg::IDX_LATCH, rnd[7:0]);
    rd(tmb_pkg::IDX_LATCH, rnd[7:0]);
    wr(tmb_pkg::IDX_CNT_LO, rnd[15:8]);
    wr(tmb_pkg::IDX_CNT_HI, rnd[23:16]);
    rd(tmb_pkg::IDX_CNT_LO, rnd[15:8]);
    rd(tmb_pkg::IDX_CNT_HI, rnd[23:16]);
    rd(tmb_pkg::IDX_LATCH, rnd[23:16]);
    wr(tmb_pkg::IDX_CMP_LO, rnd[31:24]);
    wr(tmb_pkg::IDX_CMP_HI, rnd[7:0]);
    rd(tmb_pkg::IDX_CMP_LO, rnd[31:24]);
    rd(tmb_pkg::IDX_CMP_HI, rnd[7:0]);
    $display("test wide_access done");
    wr(tmb_pkg::IDX_CMP_LO, {4'h1, rnd[3:0]});
    wr(tmb_pkg::IDX_CMP_HI, 8'h00);
    wr(tmb_pkg::IDX_CNT_LO, 8'h00);
    wr(tmb_pkg::IDX_CNT_HI, 8'h00);
    wr(tmb_pkg::IDX_IRQ_EN, 8'h01);
    wr(tmb_pkg::IDX_CTRL_A, 8'h01);
    rd(tmb_pkg::IDX_RUN_STAT, 8'h01);
    wait_irq(64);
    wr(tmb_pkg::IDX_CTRL_A, 8'h00);
    rd(tmb_pkg::IDX_RUN_STAT, 8'h00);
    rd(tmb_pkg::IDX_IRQ_FLAG, 8'h01);
    wr(tmb_pkg::IDX_IRQ_FLAG, 8'h01);
    rd(tmb_pkg::IDX_IRQ_FLAG, 8'h00);
    $display("test periodic done");
    wr(tmb_pkg::IDX_CTRL_TWO, 8'h07);
    wr(tmb_pkg::IDX_CMP_LO, 8'h20);
    wr(tmb_pkg::IDX_CMP_HI, 8'h5A);
    rd(tmb_pkg::IDX_CMP_HI, 8'h5A);
    rd(tmb_pkg::IDX_CMP_LO, 8'h20);
    wr(tmb_pkg::IDX_CNT_LO, 8'h00);
    wr(tmb_pkg::IDX_CNT_HI, 8'h00);
    wr(tmb_pkg::IDX_CTRL_A, 8'h01);
    wait_irq(80);
    wr(tmb_pkg::IDX_CTRL_A, 8'h00);
    wr(tmb_pkg::IDX_IRQ_FLAG, 8'h01);
    $display("test eight_bit_pwm_mode done");
    wr(tmb_pkg::IDX_EVENT_CTRL, 8'h01);
    wr(tmb_pkg::IDX_CTRL_A, 8'h01);
    for (int m = 2; m <= 5; m++) begin
      wr(tmb_pkg::IDX_CTRL_TWO, 8'(m));
      pulse(3);
      pulse(3);
      rd(tmb_pkg::IDX_IRQ_FLAG, 8'h01);
      rdx(tmb_pkg::IDX_CMP_LO);
      rd(tmb_pkg::IDX_IRQ_FLAG, 8'h00);
    end
    $display("test capture_modes done");
    wr(tmb_pkg::IDX_CTRL_TWO, 8'h02);
    pulse(2);
    t1 = t_ev;
    rdx(tmb_pkg::IDX_CMP_LO);
    c1[7:0] = cpu.rdata[7:0];
    rdx(tmb_pkg::IDX_CMP_HI);
    c1[15:8] = cpu.rdata[7:0];
    rnd = lfsr_next(rnd);
    repeat (rnd[4:0]) @(posedge pclk);
    pulse(2);
    rdx(tmb_pkg::IDX_CMP_LO);
    c2[7:0] = cpu.rdata[7:0];
    rdx(tmb_pkg::IDX_CMP_HI);
    c2[15:8] = cpu.rdata[7:0];
    check({17'h0, c2 - c1}, {17'h0, t_ev - t1});
    wr(tmb_pkg::IDX_EVENT_CTRL, 8'h00);
    pulse(2);
    rd(tmb_pkg::IDX_IRQ_FLAG, 8'h00);
    $display("test capture_value done");
    wr(tmb_pkg::IDX_EVENT_CTRL, 8'h01);
    @(posedge pclk);
    debug_break <= 1'b1;
    pulse(2);
    rd(tmb_pkg::IDX_RUN_STAT, 8'h00);
    rd(tmb_pkg::IDX_IRQ_FLAG, 8'h00);
    wr(tmb_pkg::IDX_DEBUG, 8'h01);
    rd(tmb_pkg::IDX_RUN_STAT, 8'h01);
    pulse(2);
    rd(tmb_pkg::IDX_IRQ_FLAG, 8'h01);
    @(posedge pclk);
    debug_break <= 1'b0;
    rdx(tmb_pkg::IDX_CMP_LO);
    $display("test debug done");
    // Time-out and single-shot: counting only starts on the event edge
    for (int m = 1; m <= 6; m += 5) begin
      wr(tmb_pkg::IDX_CTRL_A, 8'h00);
      wr(tmb_pkg::IDX_CTRL_TWO, 8'(m));
      wr(tmb_pkg::IDX_CMP_LO, 8'h18);
      wr(tmb_pkg::IDX_CMP_HI, 8'h00);
      wr(tmb_pkg::IDX_CNT_LO, 8'h00);
      wr(tmb_pkg::IDX_CNT_HI, 8'h00);
      wr(tmb_pkg::IDX_CTRL_A, 8'h01);
      rd(tmb_pkg::IDX_IRQ_FLAG, 8'h00);
      pulse(40);
      rd(tmb_pkg::IDX_IRQ_FLAG, 8'h01);
      rd(tmb_pkg::IDX_RUN_STAT, 8'h00);
      wr(tmb_pkg::IDX_IRQ_FLAG, 8'h01);
    end
    $display("test top_modes done");
    summarize();
  end
endmodule : tb
`default_nettype wire
